// ### rtl/flash_row_program_ctrl.v
/*
 Run-time self-programming controller for on-chip program flash.
 Holds the row latches, table page, unlock sequencer, control register
 and the start / completion handshake to the flash array.
 Assumes the core issues one table or register access at a time, honours
 cpu_stall, and that the array reports each started operation with
 flash_done or flash_abort.
 Holding latches are never cleared, by reset or by a program; software
 reloads every word it cares about before each row program.
*/
// Overview of operation
// - Flash is organised in rows of 32 instruction words, 96 bytes.
// - Erase 1, 2 or 4 rows at once; program exactly one row.
// - Erase blocks and rows are aligned to their own size from zero.
// - Table writes fill holding latches; flash written only on program start.
// - Program works with any latch count; 64 word writes (32 low, 32 high) fill a row.
// - Latches take writes in any order; latest write wins.
// - Each table write updates one latch word in two cycles.
// - Target address is table page concatenated with 16-bit effective address.
// - Low table ops reach bits 15..0, high ops 23..16, word or byte.
// - Key register is write-only; 55h then AAh must precede a start.
// - Core is stalled while a program or erase runs.
// - Bit 15 starts a self-timed operation, cleared by hardware at the end.
// - Bit 14 enables program and erase; clear inhibits them.
// - Bit 13 flags improper sequence or termination; zero after normal end.
// - Bit 6 picks erase when set, program when clear, using the code.
// - Codes 011010, 011001, 011000 erase four, two, one rows.
// - Codes 0101xx, 0100xx, 0011xx erase config, data EEPROM, general block.
// - With erase clear, code 0001xx programs one row from the latches.
// - Codes 1010xx, 1001xx bulk erase, only in serial programming mode.
// - Unassigned operation codes do nothing when started.
// - Row erases pick rows from the table pointer address.
// - Bit 12 only matters for data EEPROM, exists only with EEPROM.
// - Table page top bit selects user (0) or configuration (1) space.
// - Table writes to configuration space are dropped; reads still run.
`timescale 1ns/1ps
`default_nettype none
`include "flash_row_program_ctrl_defs.vh"

module flash_row_program_ctrl #(
   parameter ROW_WORDS = `ROW_WORDS,
   parameter HAS_EEPROM = 1
) (
   // Clock and reset
   input wire mclk,
   input wire resetn,
   // Special function register writes and reads from the core
   input wire ctl_wr,
   input wire [15:0] ctl_wdata,
   input wire key_wr,
   input wire [7:0] key_wdata,
   input wire page_wr,
   input wire [7:0] page_wdata,
   output wire [15:0] flash_op_control,
   output wire [7:0] table_page_reg,
   // Table operations from the core
   input wire tbl_req,
   input wire tbl_write,
   input wire tbl_high,
   input wire tbl_byte,
   input wire [15:0] tbl_ea,
   input wire [15:0] tbl_wdata,
   output reg [15:0] tbl_rdata,
   output wire tbl_done,
   output wire cpu_stall,
   // Mode strap
   input wire serial_prog_mode,
   // Flash array side
   output wire [23:0] rd_addr,
   input wire [23:0] rd_data,
   output reg flash_go,
   output reg [2:0] flash_kind,
   output reg [23:0] flash_addr,
   output reg [2:0] flash_rows,
   output reg program_only,
   input wire [4:0] lat_idx,
   output reg [23:0] lat_data,
   input wire flash_done,
   input wire flash_abort
);

   // One-hot sequencer and key progress codes
   localparam ST_IDLE = 2'b01;
   localparam ST_RUN = 2'b10;
   localparam K_NONE = 2'b01;
   localparam K_HALF = 2'b10;

   reg [1:0] state_q;
   reg [1:0] key_q;
   reg armed_q;
   reg start_q;
   reg enable_q;
   reg error_q;
   reg pgm_only_q;
   reg erase_q;
   reg [5:0] opcode_q;
   reg [7:0] page_q;
   reg [23:0] tptr_q;
   reg tbl_busy_q;
   reg [23:0] lat_mem [0:ROW_WORDS-1];

   // Decoded operation
   reg op_valid;
   reg [2:0] op_kind;
   reg [2:0] op_rows;
   reg [23:0] op_addr;
   wire [3:0] op_hi;
   wire start_try;
   wire start_ok;
   wire tbl_take;
   wire tbl_cfg;
   wire [23:0] tbl_addr;
   wire [4:0] wr_idx;

   assign op_hi = opcode_q[5:2];
   assign start_try = ctl_wr && ctl_wdata[`CTL_START_BIT] && !start_q;
   assign start_ok = start_try && armed_q && enable_q;
   assign tbl_take = tbl_req && !tbl_busy_q && state_q == ST_IDLE;
   assign tbl_addr = {page_q, tbl_ea};
   assign tbl_cfg = page_q[7];
   assign wr_idx = tbl_ea[`ROW_ADDR_BITS-1:1];
   assign rd_addr = tbl_addr;
   assign tbl_done = tbl_busy_q;
   // A request not yet taken stalls the core too, so it never runs ahead of its access
   assign cpu_stall = (state_q == ST_RUN) ||
      start_ok ||
      (tbl_req && !tbl_busy_q);
   assign table_page_reg = page_q;
   assign flash_op_control = {start_q, enable_q, error_q, pgm_only_q,
      5'h00, erase_q, opcode_q};

   // Operation decode from erase bit and code
   always @* begin
      op_valid = 1'b0;
      op_kind = `KIND_PROG_ROW;
      op_rows = 3'h1;
      op_addr = tptr_q;
      if (erase_q) begin
         if (opcode_q == `OP_ERASE_4ROW) begin
            op_valid = 1'b1;
            op_kind = `KIND_ERASE_ROWS;
            op_rows = 3'h4;
            op_addr = {tptr_q[23:`ROW_ADDR_BITS+2], 8'h00};
         end else if (opcode_q == `OP_ERASE_2ROW) begin
            op_valid = 1'b1;
            op_kind = `KIND_ERASE_ROWS;
            op_rows = 3'h2;
            op_addr = {tptr_q[23:`ROW_ADDR_BITS+1], 7'h00};
         end else if (opcode_q == `OP_ERASE_1ROW) begin
            op_rows = 3'h1;
            op_valid = 1'b1;
            op_kind = `KIND_ERASE_ROWS;
            op_addr = {tptr_q[23:`ROW_ADDR_BITS], 6'h00};
         end else if (op_hi == `OPH_ERASE_CFG) begin
            op_valid = 1'b1;
            op_kind = `KIND_ERASE_CFG;
         end else if (op_hi == `OPH_ERASE_EEP) begin
            // Without data EEPROM this code is a no-op
            op_valid = (HAS_EEPROM != 0);
            op_kind = `KIND_ERASE_EEP;
         end else if (op_hi == `OPH_ERASE_GEN) begin
            op_valid = 1'b1;
            op_kind = `KIND_ERASE_GEN;
         end else if (op_hi == `OPH_ERASE_BOOT) begin
            // Bulk erases are refused outside serial programming mode
            op_valid = serial_prog_mode;
            op_kind = `KIND_ERASE_BOOT;
         end else if (op_hi == `OPH_ERASE_ALL) begin
            op_valid = serial_prog_mode;
            op_kind = `KIND_ERASE_ALL;
         end
      end else if (op_hi == `OPH_PROGRAM) begin
         op_valid = 1'b1;
         op_kind = `KIND_PROG_ROW;
         op_rows = 3'h1;
         op_addr = {tptr_q[23:`ROW_ADDR_BITS], 6'h00};
      end
   end

   // Unlock sequencer: any other register write breaks the sequence
   // Arming lasts one write, so a stray store cannot leave the array unlocked
   always @(posedge mclk) begin
      if (!resetn) begin
         key_q <= K_NONE;
         armed_q <= 1'b0;
      end else if (key_wr) begin
         case (key_q)
            K_NONE: begin
               key_q <= (key_wdata == `KEY_FIRST) ? K_HALF : K_NONE;
               armed_q <= 1'b0;
            end
            K_HALF: begin
               // Second key must follow the first directly
               key_q <= K_NONE;
               armed_q <= (key_wdata == `KEY_SECOND);
            end
            default: begin
               key_q <= K_NONE;
               armed_q <= 1'b0;
            end
         endcase
      end else if (ctl_wr || page_wr || tbl_take) begin
         key_q <= K_NONE;
         armed_q <= 1'b0;
      end
   end

   // Control register and operation sequencer
   always @(posedge mclk) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         start_q <= 1'b0;
         enable_q <= 1'b0;
         error_q <= 1'b0;
         pgm_only_q <= 1'b0;
         erase_q <= 1'b0;
         opcode_q <= 6'h00;
         flash_go <= 1'b0;
         flash_kind <= `KIND_PROG_ROW;
         flash_addr <= 24'h000000;
         flash_rows <= 3'h1;
         program_only <= 1'b0;
      end else begin
         flash_go <= 1'b0;
         // Field writes while running are ignored; start is owned by hardware then
         if (ctl_wr && state_q == ST_IDLE) begin
            enable_q <= ctl_wdata[`CTL_ENABLE_BIT];
            error_q <= ctl_wdata[`CTL_ERROR_BIT];
            pgm_only_q <= (HAS_EEPROM != 0) && ctl_wdata[`CTL_PROGRAM_ONLY_BIT_BIT];
            erase_q <= ctl_wdata[`CTL_ERASE_BIT];
            opcode_q <= ctl_wdata[5:0];
         end
         case (state_q)
            ST_IDLE: begin
               // Decode uses the settings held before this write
               // A refused start still loads the other fields, like any control write
               if (start_try && !start_ok) begin
                  error_q <= 1'b1;
               end else if (start_ok && op_valid) begin
                  start_q <= 1'b1;
                  state_q <= ST_RUN;
                  flash_go <= 1'b1;
                  flash_kind <= op_kind;
                  flash_addr <= op_addr;
                  flash_rows <= op_rows;
                  program_only <= pgm_only_q;
               end
               // An unassigned code leaves the start bit low: no operation
            end
            ST_RUN: begin
               // Abort wins over done if the array reports both
               if (flash_abort) begin
                  start_q <= 1'b0;
                  error_q <= 1'b1;
                  state_q <= ST_IDLE;
               end else if (flash_done) begin
                  start_q <= 1'b0;
                  error_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               start_q <= 1'b0;
            end
         endcase
      end
   end

   // Page register and table pointer
   always @(posedge mclk) begin
      if (!resetn) begin
         page_q <= 8'h00;
         tptr_q <= 24'h000000;
      end else begin
         if (page_wr) begin
            page_q <= page_wdata;
         end
         // A dropped configuration write leaves the pointer where it was
         if (tbl_take && tbl_write && !tbl_cfg) begin
            tptr_q <= tbl_addr;
         end
      end
   end

   // Table access timing: request cycle plus completion cycle.
   // A request held through done is taken again on the following cycle.
   always @(posedge mclk) begin
      if (!resetn) begin
         tbl_busy_q <= 1'b0;
      end else begin
         tbl_busy_q <= tbl_take;
      end
   end

   // Table read data: high word carries a zero phantom byte
   // Data is taken in the request cycle, so it stands while done is high
   always @(posedge mclk) begin
      if (!resetn) begin
         tbl_rdata <= 16'h0000;
      end else if (tbl_take && !tbl_write) begin
         if (tbl_high) begin
            tbl_rdata <= (tbl_byte && tbl_ea[0]) ? 16'h0000 : {8'h00, rd_data[23:16]};
         end else if (tbl_byte) begin
            tbl_rdata <= {8'h00, tbl_ea[0] ? rd_data[15:8] : rd_data[7:0]};
         end else begin
            tbl_rdata <= rd_data[15:0];
         end
      end
   end

   // Holding latches; no reset so the array maps onto plain storage.
   // Latest write to a latch replaces earlier ones, in any order.
   always @(posedge mclk) begin
      if (tbl_take && tbl_write && !tbl_cfg) begin
         if (tbl_high) begin
            if (!(tbl_byte && tbl_ea[0])) begin
               lat_mem[wr_idx][23:16] <= tbl_wdata[7:0];
            end
         end else if (tbl_byte) begin
            if (tbl_ea[0]) begin
               lat_mem[wr_idx][15:8] <= tbl_wdata[7:0];
            end else begin
               lat_mem[wr_idx][7:0] <= tbl_wdata[7:0];
            end
         end else begin
            lat_mem[wr_idx][15:0] <= tbl_wdata;
         end
      end
   end

   // Latch readout for the array during a row program
   // Runs every cycle; the array owns the index and ignores the data otherwise
   always @(posedge mclk) begin
      if (!resetn) begin
         lat_data <= 24'h000000;
      end else begin
         lat_data <= lat_mem[lat_idx];
      end
   end

endmodule
`default_nettype wire

// ### rtl/flash_row_program_ctrl_defs.vh
/*
 Constants for the flash row program controller: control register fields,
 operation codes, geometry and table access timing.
 Assumes inclusion by bare name from the design file.
*/
`ifndef FLASH_ROW_PROGRAM_CTRL_DEFS_VH
`define FLASH_ROW_PROGRAM_CTRL_DEFS_VH

// Control register fields
`define CTL_START_BIT 15
`define CTL_ENABLE_BIT 14
`define CTL_ERROR_BIT 13
`define CTL_PROGRAM_ONLY_BIT_BIT 12
`define CTL_ERASE_BIT 6
`define CTL_RESET 16'h0000
`define CTL_WMASK 16'h507F

// Unlock key values
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA

// Operation codes, top four bits unless full six bits are decoded
`define OP_ERASE_4ROW 6'h1A
`define OP_ERASE_2ROW 6'h19
`define OP_ERASE_1ROW 6'h18
`define OPH_ERASE_CFG 4'h5
`define OPH_ERASE_EEP 4'h4
`define OPH_ERASE_GEN 4'h3
`define OPH_PROGRAM 4'h1
`define OPH_ERASE_BOOT 4'hA
`define OPH_ERASE_ALL 4'h9

// Operation kinds presented to the array
`define KIND_PROG_ROW 3'h0
`define KIND_ERASE_ROWS 3'h1
`define KIND_ERASE_CFG 3'h2
`define KIND_ERASE_EEP 3'h3
`define KIND_ERASE_GEN 3'h4
`define KIND_ERASE_BOOT 3'h5
`define KIND_ERASE_ALL 3'h6

// Geometry
`define ROW_WORDS 32
`define ROW_BYTES 96
`define ROW_ADDR_BITS 6

// Table write completes in two instruction cycles
`define TBL_CYCLES 2

`endif

// ### verif/flash_row_program_ctrl_assertions.sv
/* Port assertions for the flash row program controller.
 Bound to the top module from the bench; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
`include "flash_row_program_ctrl_defs.vh"
module flash_row_program_ctrl_assertions (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Core side
   input wire logic ctl_wr,
   input wire logic [15:0] ctl_wdata,
   input wire logic key_wr,
   input wire logic [7:0] key_wdata,
   input wire logic [15:0] flash_op_control,
   input wire logic tbl_req,
   input wire logic tbl_done,
   input wire logic cpu_stall,
   // Array side
   input wire logic flash_go,
   input wire logic flash_done,
   input wire logic flash_abort
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   // The bench spaces register writes two cycles apart
   sequence keys_then_start;
      key_wr && key_wdata == `KEY_FIRST ##2 key_wr && key_wdata == `KEY_SECOND
         ##2 ctl_wr && ctl_wdata[15];
   endsequence
   sequence row_erase_armed;
      !flash_op_control[15] && flash_op_control[14:0] == 15'h4058;
   endsequence
   keyed_start_a: assert property (keys_then_start ##0 row_erase_armed |=> flash_go)
      else $error("keyed start gave no array start");
   go_cause_a: assert property (flash_go |-> $past(ctl_wr) && $past(flash_op_control[14]))
      else $error("array start without enabled start write");
   go_running_a: assert property (flash_go |-> (flash_op_control[15] && cpu_stall) ##1 !flash_go)
      else $error("array start not a single busy pulse");
   done_clears_a: assert property (
      flash_done && flash_op_control[15] |=> !flash_op_control[15] && !flash_op_control[13])
      else $error("completion left start or error set");
   abort_flags_a: assert property (
      flash_abort && flash_op_control[15] |=> flash_op_control[13] && !flash_op_control[15])
      else $error("termination not flagged");
   busy_stalls_a: assert property (flash_op_control[15] |-> cpu_stall)
      else $error("core not stalled while busy");
   denied_start_a: assert property (
      ctl_wr && ctl_wdata[15] && flash_op_control[15:14] == 2'b00 |=> flash_op_control[13] && !flash_go)
      else $error("disabled start not refused");
   tbl_two_cycle_a: assert property ($rose(tbl_done) |-> $past(tbl_req) ##1 !tbl_done)
      else $error("table access not two cycles");
endmodule
`default_nettype wire

// ### verif/flash_array_model.sv
/* Behavioural flash array on the controller's array side.
 Assumes flash_kind holds steady while an operation runs. */
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
   parameter int BUSY = 4
) (
   // Clock
   input wire logic mclk,
   // Array handshake
   input wire logic flash_go,
   input wire logic [2:0] flash_kind,
   output logic [4:0] lat_idx,
   input wire logic [23:0] lat_data,
   output logic flash_done,
   output logic flash_abort,
   // Scenario control
   input wire logic end_in_abort
);
   logic [23:0] row_q [0:31];
   int n;
   initial begin
      lat_idx = 5'h00;
      flash_done = 1'b0;
      flash_abort = 1'b0;
      forever begin
         @(posedge mclk);
         if (flash_go === 1'b1) begin
            // Latch data lags its index by a cycle, so word n-1 lands at step n
            for (n = 0; n <= 32; n++) begin
               lat_idx <= n[4:0];
               @(posedge mclk);
               if (n > 0 && flash_kind === 3'h0) row_q[n - 1] = lat_data;
            end
            repeat (BUSY) @(posedge mclk);
            flash_done <= !end_in_abort;
            flash_abort <= end_in_abort;
            @(posedge mclk);
            flash_done <= 1'b0;
            flash_abort <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### verif/flash_row_program_ctrl_bench.sv
/* Self-checking bench for the flash row program controller.
 Drives register and table accesses as the core would; array model beyond. */
`timescale 1ns/1ps
`default_nettype none
module flash_row_program_ctrl_bench;
   logic mclk, resetn, ctl_wr, key_wr, page_wr, tbl_req, tbl_write, tbl_high, tbl_byte;
   logic serial_prog_mode, flash_done, flash_abort, tbl_done, cpu_stall, flash_go;
   logic program_only, end_in_abort;
   logic [2:0] flash_kind, flash_rows, go_kind, go_rows;
   logic [4:0] lat_idx;
   logic [7:0] key_wdata, page_wdata, table_page_reg;
   logic [15:0] ctl_wdata, tbl_ea, tbl_wdata, tbl_rdata, flash_op_control;
   logic [23:0] rd_addr, rd_data, flash_addr, lat_data, go_addr;
   logic [15:0] setups [0:8] = '{16'h4058, 16'h4059, 16'h405A, 16'h404C, 16'h4054,
      16'h5050, 16'h4068, 16'h4064, 16'h407F};
   logic [2:0] kinds [0:8] = '{3'h1, 3'h1, 3'h1, 3'h4, 3'h2, 3'h3, 3'h5, 3'h6, 3'h0};
   integer failures = 0, checked = 0, gos = 0, i;
   // Array read data scrambles the address so a wrong page or half shows
   assign rd_data = rd_addr ^ 24'hC31234;
   flash_row_program_ctrl dut_u (.mclk, .resetn, .ctl_wr, .ctl_wdata, .key_wr, .key_wdata,
      .page_wr, .page_wdata, .flash_op_control, .table_page_reg, .tbl_req, .tbl_write,
      .tbl_high, .tbl_byte, .tbl_ea, .tbl_wdata, .tbl_rdata, .tbl_done, .cpu_stall,
      .serial_prog_mode, .rd_addr, .rd_data, .flash_go, .flash_kind, .flash_addr,
      .flash_rows, .program_only, .lat_idx, .lat_data, .flash_done, .flash_abort);
   flash_array_model array_u (.mclk, .flash_go, .flash_kind, .lat_idx, .lat_data,
      .flash_done, .flash_abort, .end_in_abort);
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (flash_go === 1'b1) begin
         gos <= gos + 1;
         go_kind <= flash_kind;
         go_rows <= flash_rows;
         go_addr <= flash_addr;
      end
   end
   task automatic chk(input string what, input logic [23:0] exp, got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic limit(input integer k, lim);
      if (k >= lim) begin
         chk("wait bound", 24'h0, 24'h1);
         tally_and_finish();
      end
   endtask
   // sel 0 control, 1 key, 2 page; an idle cycle follows each write
   task automatic wr(input logic [1:0] sel, input logic [15:0] d);
      ctl_wr <= sel == 2'h0;
      key_wr <= sel == 2'h1;
      page_wr <= sel == 2'h2;
      ctl_wdata <= d;
      key_wdata <= d[7:0];
      page_wdata <= d[7:0];
      @(posedge mclk);
      {ctl_wr, key_wr, page_wr} <= 3'h0;
      @(posedge mclk);
   endtask
   // f is {write, high, byte}
   task automatic tbl(input logic [2:0] f, input logic [15:0] ea, wd);
      integer k;
      {tbl_write, tbl_high, tbl_byte} <= f;
      tbl_req <= 1'b1;
      tbl_ea <= ea;
      tbl_wdata <= wd;
      k = 0;
      do begin
         @(negedge mclk);
         k++;
      end while (tbl_done !== 1'b1 && k < 40);
      limit(k, 40);
      @(posedge mclk);
      tbl_req <= 1'b0;
      @(posedge mclk);
   endtask
   // Setup goes first: the start decode reads the fields held before the start write
   task automatic op(input logic [15:0] setup, input logic keyed, input logic [23:0] go, err);
      integer g, k;
      g = gos;
      wr(2'h0, setup);
      if (keyed) wr(2'h1, 16'h0055);
      if (keyed) wr(2'h1, 16'h00AA);
      wr(2'h0, setup | 16'h8000);
      @(negedge mclk);
      if (go) chk("stall", 24'h1, 24'(cpu_stall));
      k = 0;
      while (flash_op_control[15] !== 1'b0 && k < 200) begin
         @(negedge mclk);
         k++;
      end
      limit(k, 200);
      @(posedge mclk);
      chk("ops started", go, 24'(gos - g));
      chk("error flag", err, 24'(flash_op_control[13]));
   endtask
   initial begin
      {resetn, ctl_wr, key_wr, page_wr, tbl_req, tbl_write, tbl_high, tbl_byte} = 8'h00;
      {serial_prog_mode, end_in_abort, ctl_wdata, key_wdata, page_wdata} = 34'h0;
      {tbl_ea, tbl_wdata} = 32'h0;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      @(negedge mclk);
      chk("control reset", 24'h0, 24'(flash_op_control));
      @(posedge mclk);
      $display("reset test done");
      wr(2'h2, 16'h0001);
      chk("page reg", 24'h01, 24'(table_page_reg));
      tbl(3'h4, 16'h0004, 16'h1111);
      tbl(3'h4, 16'h0004, 16'hBEEF);
      tbl(3'h6, 16'h0004, 16'h0042);
      tbl(3'h4, 16'h0006, 16'h2222);
      tbl(3'h5, 16'h0007, 16'h00A5);
      tbl(3'h7, 16'h0006, 16'h0077);
      wr(2'h2, 16'h0081);
      chk("page reg", 24'h81, 24'(table_page_reg));
      tbl(3'h4, 16'h0006, 16'h9999);
      tbl(3'h2, 16'h0010, 16'h0000);
      chk("config read", 24'h0042, 24'(tbl_rdata));
      wr(2'h2, 16'h0001);
      tbl(3'h0, 16'h0010, 16'h0000);
      chk("read low", 24'h1224, 24'(tbl_rdata));
      tbl(3'h2, 16'h0010, 16'h0000);
      chk("read high", 24'h00C2, 24'(tbl_rdata));
      tbl(3'h1, 16'h0011, 16'h0000);
      chk("read byte", 24'h0012, 24'(tbl_rdata));
      tbl(3'h3, 16'h0011, 16'h0000);
      chk("read phantom", 24'h0000, 24'(tbl_rdata));
      $display("table test done");
      op(16'h4004, 1'b1, 24'h1, 24'h0);
      chk("program kind", 24'h0, 24'(go_kind));
      chk("program row", 24'h010000, go_addr);
      chk("latch 2", 24'h42BEEF, array_u.row_q[2]);
      chk("latch 3", 24'h77A522, array_u.row_q[3]);
      $display("program test done");
      // Pointer sits off every block boundary, so each erase size clears different bits
      tbl(3'h4, 16'h00C6, 16'h0000);
      serial_prog_mode <= 1'b1;
      for (i = 0; i < 9; i++) begin
         op(setups[i], 1'b1, 24'(i < 8), 24'h0);
         if (i < 8) chk("erase kind", 24'(kinds[i]), 24'(go_kind));
         if (i < 3) chk("erase rows", 24'(1 << i), 24'(go_rows));
         if (i < 3) chk("erase base", 24'h0100C6 & ~((24'h40 << i) - 24'h1), go_addr);
         if (i == 5) chk("program only", 24'h1, 24'(program_only));
      end
      serial_prog_mode <= 1'b0;
      op(16'h4068, 1'b1, 24'h0, 24'h0);
      op(16'h4058, 1'b0, 24'h0, 24'h1);
      op(16'h0058, 1'b1, 24'h0, 24'h1);
      end_in_abort <= 1'b1;
      op(16'h4058, 1'b1, 24'h1, 24'h1);
      $display("erase and refusal tests done");
      tally_and_finish();
   end
endmodule
bind flash_row_program_ctrl flash_row_program_ctrl_assertions chk_u (.mclk, .resetn, .ctl_wr,
   .ctl_wdata, .key_wr, .key_wdata, .flash_op_control, .tbl_req, .tbl_done, .cpu_stall,
   .flash_go, .flash_done, .flash_abort);
`default_nettype wire
